// *** hw/bms_pkg.sv ***
// Behaviour
// - Mode pins captured at reset release
// - Three mode bits decode eight modes
// - Normal modes protect, special modes allow writes
// - Debug active after reset only special single
// - Port E bits 1,0 inputs with pull-ups
// - Reset sets stretch enable in user modes
// - Mode pins high impedance during reset
// - Normal single chip: all pins GPIO
// - Single chip ignores pipe, strobe, rw bits
// - Normal single chip: mode written once
// - Clearing e_clock_disable gives free E clock
// - Wide modes: 16-bit muxed bus, E clock
// - Wide: Port E GPIO until enables set
// - pipe_status_enable routes pipe status, expanded
// - rw_pin_enable makes bit 2 read/write
// - Wide: low_strobe_enable makes bit 3 strobe
// - Expanded: bit 4 stretched E clock
// - Narrow: 16-bit address, data on A
// - Narrow normal: no internal visibility
// - Narrow normal: assign register written once
// - Narrow normal: bit 3 always GPIO
package bms_pkg;

	// Register byte offsets on the AHB-Lite bus
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] PORT_E_ASSIGN_REG_OFS = 8'h04;
	localparam logic [7:0] EBI_OFS  = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0c;

	// Field positions in the mode register
	localparam int unsigned MODE_LSB = 5;
	localparam int unsigned INTERNAL_VISIBILITY_BIT = 3;
	// Field positions in port_e_assign_reg
	localparam int unsigned PIPE_BIT  = 5;
	localparam int unsigned E_CLOCK_DISABLE_BIT = 4;
	localparam int unsigned LSTR_BIT  = 3;
	localparam int unsigned RDW_BIT   = 2;
	// Field position in bus_control_reg
	localparam int unsigned STRETCH_ENABLE_BIT = 0;
	// Field positions in the status register
	localparam int unsigned ST_BDM   = 0;
	localparam int unsigned ST_MLOCK = 1;
	localparam int unsigned ST_PLOCK = 2;
	localparam int unsigned ST_EXP   = 3;
	localparam int unsigned ST_WIDE  = 4;
	localparam int unsigned ST_SPEC  = 5;

	// Port E pin positions
	localparam int unsigned PE_NONMASKABLE_INT_IN = 0;
	localparam int unsigned PE_IRQ  = 1;
	localparam int unsigned PE_RW   = 2;
	localparam int unsigned PE_LSTR = 3;
	localparam int unsigned PE_E_CLOCK_OUT = 4;
	localparam int unsigned PE_PLO  = 5;
	localparam int unsigned PE_PHI  = 6;

	// Mode encodings
	localparam logic [2:0] MODE_SSC = 3'h0;
	localparam logic [2:0] MODE_ENR = 3'h1;
	localparam logic [2:0] MODE_STW = 3'h2;
	localparam logic [2:0] MODE_EWD = 3'h3;
	localparam logic [2:0] MODE_NSC = 3'h4;
	localparam logic [2:0] MODE_NNR = 3'h5;
	localparam logic [2:0] MODE_PER = 3'h6;
	localparam logic [2:0] MODE_NWD = 3'h7;

	// Reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [7:0] REG_RST  = 8'h00;

	// Bus-side signals from the core
	typedef struct packed {
		logic [15:0] addr;       // Cycle address
		logic [15:0] wdata;      // Write data
		logic        rw;         // High for read
		logic        low_byte_strobe_n;    // Low-byte strobe, active low
		logic [1:0]  pipe;       // Pipe status hi, lo
		logic        e_clock_out_free;  // Unstretched E clock
		logic        e_clock_out_str;   // Stretched E clock
		logic        addr_phase; // High in address phase
		logic        internal;   // Cycle stays internal
	} bms_core_bus_t;

	// General-purpose port values and directions
	typedef struct packed {
		logic [7:0] a_out;
		logic [7:0] a_dir;
		logic [7:0] b_out;
		logic [7:0] b_dir;
		logic [7:0] e_out;
		logic [7:0] e_dir;
	} bms_gpio_t;

	// Pad drive for ports A, B and E
	typedef struct packed {
		logic [7:0] a_out;
		logic [7:0] a_oe;
		logic [7:0] b_out;
		logic [7:0] b_oe;
		logic [7:0] e_out;
		logic [7:0] e_oe;
		logic [7:0] e_pull;
		logic [7:0] ab_pull;
	} bms_pads_t;

endpackage

// *** hw/bms_mode_pins.sv ***
`timescale 1ns/10ps
module bms_mode_pins (
	input  wire logic               ref_clk_i,
	input  wire logic               reset_n_i,
	// AHB-Lite slave
	input  wire logic               hsel_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic [31:0]        hwdata_i,
	input  wire logic               hready_i,
	output logic [31:0]             hrdata_o,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	// Core side
	input  wire bms_pkg::bms_core_bus_t core_i,
	input  wire bms_pkg::bms_gpio_t gpio_i,
	input  wire logic               bdm_activate_i,
	input  wire logic               bdm_release_i,
	output logic                    bdm_active_o,
	output logic [2:0]              mode_o,
	// Pins
	input  wire logic               mode_select_hi_i,
	input  wire logic [7:0]         port_a_i,
	input  wire logic [7:0]         port_b_i,
	input  wire logic [7:0]         port_e_i,
	output bms_pkg::bms_pads_t      pads_o,
	output logic [23:0]             pin_in_o
);

	// Mode decode helpers; each class test is used once, by the class
	// decode below, and keeping it in one place stops the decodes drifting
	function automatic logic f_single(input logic [2:0] m);
		f_single = (m == bms_pkg::MODE_SSC) || (m == bms_pkg::MODE_NSC);
	endfunction
	function automatic logic f_wide(input logic [2:0] m);
		f_wide = (m == bms_pkg::MODE_STW) || (m == bms_pkg::MODE_EWD) ||
			(m == bms_pkg::MODE_NWD);
	endfunction
	function automatic logic f_narrow(input logic [2:0] m);
		f_narrow = (m == bms_pkg::MODE_ENR) || (m == bms_pkg::MODE_NNR);
	endfunction

	// Register state
	logic [2:0]  mode;        // Current operating mode
	logic        internal_visibility;        // internal_visibility
	logic        pipe_en;     // pipe_status_enable
	logic        e_clock_disable;       // e_clock_disable
	logic        lstr_en;     // low_strobe_enable
	logic        rdw_en;      // rw_pin_enable
	logic        stretch_enable;        // stretch_enable
	logic        mode_lock;   // Mode register consumed its write
	logic        port_e_assign_reg_lock;   // Assign register consumed its write
	logic        bdm_act;     // Background debug active
	logic        rst_q;       // Reset seen released last cycle
	logic        init;        // First cycle after reset release
	// Pin input path
	logic [23:0] sync1;       // Pin synchroniser, first stage
	logic [23:0] sync2;       // Pin synchroniser, second stage
	logic        msel_s1;     // mode_select_hi first stage
	logic        msel_s2;     // mode_select_hi second stage
	logic [2:0]  strap;       // Synchronised mode straps
	// Register bus state
	logic        wr_q;        // Pending write data phase
	logic        rd_q;        // Pending read data phase
	logic [7:0]  addr_q;      // Latched register offset
	logic [7:0]  wbyte;       // Written byte
	// Decoded mode classes
	logic        exp_m;       // Expanded mode
	logic        wide_m;      // Wide mode
	logic        narrow_m;    // Narrow mode
	logic        spec_m;      // Special mode
	logic        nnr_m;       // Normal expanded narrow
	logic        internal_visibility_eff;    // Visibility after mode gating
	logic        e_clock_out_val;    // E clock level on the pin
	bms_pkg::bms_pads_t next_pads; // Pad drive before the flops

	// Two-stage synchronisers for every pin input
	// No reset here: the straps must keep flowing through while reset
	// is held, so the mode seen at release is a settled pin level
	always_ff @(posedge ref_clk_i) begin
		sync1   <= {port_a_i, port_b_i, port_e_i};
		sync2   <= sync1;
		msel_s1 <= mode_select_hi_i;
		msel_s2 <= msel_s1;
	end

	assign pin_in_o = sync2;
	assign strap    = {msel_s2, sync2[bms_pkg::PE_PHI],
		sync2[bms_pkg::PE_PLO]};

	// Detect the rising edge of reset
	// Cleared while reset is low, so the first high edge is always
	// seen, also for a reset that arrives in the middle of a run
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			rst_q <= 1'b0;
		end else begin
			rst_q <= 1'b1;
		end
	end

	// Straps read at init have been sampled while reset was still low
	// (two stages behind the pins), so a strap that the far side drops
	// at release cannot leak into the captured mode
	assign init = reset_n_i & ~rst_q;

	// Mode class decode
	// Peripheral mode is neither single chip nor expanded; the far side
	// must never strap it, so no bus function is offered there
	assign exp_m    = ~f_single(mode) & (mode != bms_pkg::MODE_PER);
	assign wide_m   = f_wide(mode);
	assign narrow_m = f_narrow(mode);
	assign spec_m   = ~mode[2];
	assign nnr_m    = (mode == bms_pkg::MODE_NNR);
	assign internal_visibility_eff = internal_visibility & exp_m & ~nnr_m;

	// AHB-Lite address phase capture; zero wait states
	// The data phase always follows in the next cycle; the offset is
	// kept so the write lands at the end of that phase
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= bms_pkg::REG_RST;
		end else if (hready_i) begin
			wr_q   <= hsel_i & htrans_i[1] & hwrite_i;
			rd_q   <= hsel_i & htrans_i[1] & ~hwrite_i;
			addr_q <= haddr_i[7:0];
		end
	end

	// Every transfer completes at once with an OKAY answer; refused
	// writes are simply dropped, so software must read back to check
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign wbyte       = hwdata_i[7:0];

	// Read mux; unmapped offsets and idle phases read zero
	// Combinational from the registers, so a read that directly
	// follows a write already sees the new value
	always_comb begin
		hrdata_o = 32'h0000_0000;
		if (rd_q) begin
			case (addr_q)
				bms_pkg::MODE_OFS: begin
					hrdata_o[bms_pkg::MODE_LSB +: 3] = mode;
					hrdata_o[bms_pkg::INTERNAL_VISIBILITY_BIT]      = internal_visibility;
				end
				bms_pkg::PORT_E_ASSIGN_REG_OFS: begin
					hrdata_o[bms_pkg::PIPE_BIT]  = pipe_en;
					hrdata_o[bms_pkg::E_CLOCK_DISABLE_BIT] = e_clock_disable;
					hrdata_o[bms_pkg::LSTR_BIT]  = lstr_en;
					hrdata_o[bms_pkg::RDW_BIT]   = rdw_en;
				end
				bms_pkg::EBI_OFS: begin
					hrdata_o[bms_pkg::STRETCH_ENABLE_BIT] = stretch_enable;
				end
				bms_pkg::STAT_OFS: begin
					hrdata_o[bms_pkg::ST_BDM]   = bdm_act;
					hrdata_o[bms_pkg::ST_MLOCK] = mode_lock;
					hrdata_o[bms_pkg::ST_PLOCK] = port_e_assign_reg_lock;
					hrdata_o[bms_pkg::ST_EXP]   = exp_m;
					hrdata_o[bms_pkg::ST_WIDE]  = wide_m;
					hrdata_o[bms_pkg::ST_SPEC]  = spec_m;
				end
				default: begin
					hrdata_o = 32'h0000_0000;
				end
			endcase
		end
	end

	// Mode register: straps at reset release, then guarded writes
	// The write-once lock is never cleared by a write; only a new
	// reset gives software another chance to pick the bus mode
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			mode      <= bms_pkg::MODE_RST;
			internal_visibility      <= 1'b0;
			mode_lock <= 1'b0;
		end else if (init) begin
			mode <= strap;
		end else if (wr_q && addr_q == bms_pkg::MODE_OFS) begin
			if (spec_m) begin
				// Special modes may rewrite freely
				mode <= wbyte[bms_pkg::MODE_LSB +: 3];
				internal_visibility <= wbyte[bms_pkg::INTERNAL_VISIBILITY_BIT];
			end else if (mode == bms_pkg::MODE_NSC && !mode_lock) begin
				// One write may pick an expanded bus and visibility
				mode_lock <= 1'b1;
				internal_visibility      <= wbyte[bms_pkg::INTERNAL_VISIBILITY_BIT];
				if (wbyte[bms_pkg::MODE_LSB +: 3] == bms_pkg::MODE_NNR ||
					wbyte[bms_pkg::MODE_LSB +: 3] == bms_pkg::MODE_NWD) begin
					mode <= wbyte[bms_pkg::MODE_LSB +: 3];
				end
			end else if (mode == bms_pkg::MODE_NWD) begin
				// Mode bits stay fixed; visibility remains adjustable
				internal_visibility <= wbyte[bms_pkg::INTERNAL_VISIBILITY_BIT];
			end
		end
	end

	// Assign register and its write-once guard in normal narrow mode
	// In single chip only e_clock_disable reaches a pin; the other bits read
	// back but drive nothing, as the pin mux below only looks at them in expanded modes
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pipe_en   <= 1'b0;
			lstr_en   <= 1'b0;
			rdw_en    <= 1'b0;
			e_clock_disable     <= 1'b1;
			port_e_assign_reg_lock <= 1'b0;
		end else if (init) begin
			// E clock runs out of reset except in normal single chip
			e_clock_disable <= (strap == bms_pkg::MODE_NSC);
		end else if (wr_q && addr_q == bms_pkg::PORT_E_ASSIGN_REG_OFS &&
			!(nnr_m && port_e_assign_reg_lock)) begin
			pipe_en   <= wbyte[bms_pkg::PIPE_BIT];
			e_clock_disable     <= wbyte[bms_pkg::E_CLOCK_DISABLE_BIT];
			lstr_en   <= wbyte[bms_pkg::LSTR_BIT];
			rdw_en    <= wbyte[bms_pkg::RDW_BIT];
			port_e_assign_reg_lock <= nnr_m;
		end
	end

	// Stretch enable comes up set in every user mode
	// so the first fetch after reset also works from slow memory;
	// special modes come up unstretched
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			stretch_enable <= 1'b1;
		end else if (init) begin
			stretch_enable <= strap[2];
		end else if (wr_q && addr_q == bms_pkg::EBI_OFS) begin
			stretch_enable <= wbyte[bms_pkg::STRETCH_ENABLE_BIT];
		end
	end

	// Background debug activity; activation wins over release
	// Only special single chip starts active; every other mode waits
	// for an activation pulse from the debug side
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			bdm_act <= 1'b0;
		end else if (init) begin
			bdm_act <= (strap == bms_pkg::MODE_SSC);
		end else if (bdm_activate_i) begin
			bdm_act <= 1'b1;
		end else if (bdm_release_i) begin
			bdm_act <= 1'b0;
		end
	end

	assign bdm_active_o = bdm_act;
	assign mode_o       = mode;

	// E clock: stretched when enabled in expanded modes, and held low
	// on internal cycles that are not made visible
	// Trade-off: the forcing applies only in expanded modes, so a free
	// E clock in single chip never pauses on internal cycles
	always_comb begin
		if (exp_m && stretch_enable) begin
			e_clock_out_val = core_i.e_clock_out_str;
		end else begin
			e_clock_out_val = core_i.e_clock_out_free;
		end
		if (exp_m && core_i.internal && !internal_visibility_eff) begin
			e_clock_out_val = 1'b0;
		end
	end

	// Pin function mux
	// Port values first, then bus functions override them pin by
	// pin; anything not claimed below stays a port pin
	always_comb begin
		next_pads         = '0;
		next_pads.a_out   = gpio_i.a_out;
		next_pads.a_oe    = gpio_i.a_dir;
		next_pads.b_out   = gpio_i.b_out;
		next_pads.b_oe    = gpio_i.b_dir;
		next_pads.ab_pull = 8'h00;
		next_pads.e_out   = gpio_i.e_out;
		next_pads.e_oe    = gpio_i.e_dir;
		// Bits 0 and 1 are inputs only and get pull-ups below
		next_pads.e_oe[bms_pkg::PE_NONMASKABLE_INT_IN] = 1'b0;
		next_pads.e_oe[bms_pkg::PE_IRQ]  = 1'b0;
		if (exp_m) begin
			if (core_i.addr_phase) begin
				next_pads.a_out = core_i.addr[15:8];
				next_pads.b_out = core_i.addr[7:0];
				next_pads.a_oe  = 8'hff;
				next_pads.b_oe  = 8'hff;
			end else if (wide_m) begin
				next_pads.a_out = core_i.wdata[15:8];
				next_pads.b_out = core_i.wdata[7:0];
				next_pads.a_oe  = {8{~core_i.rw}};
				next_pads.b_oe  = {8{~core_i.rw}};
			end else if (narrow_m) begin
				// Narrow: B keeps the address, A carries data
				next_pads.a_out = core_i.wdata[7:0];
				next_pads.b_out = core_i.addr[7:0];
				next_pads.a_oe  = {8{~core_i.rw}};
				next_pads.b_oe  = 8'hff;
			end
			if (rdw_en) begin
				next_pads.e_out[bms_pkg::PE_RW] = core_i.rw;
				next_pads.e_oe[bms_pkg::PE_RW]  = 1'b1;
			end
			if (lstr_en && !nnr_m) begin
				next_pads.e_out[bms_pkg::PE_LSTR] = core_i.low_byte_strobe_n;
				next_pads.e_oe[bms_pkg::PE_LSTR]  = 1'b1;
			end
			if (pipe_en) begin
				next_pads.e_out[bms_pkg::PE_PHI] = core_i.pipe[1];
				next_pads.e_out[bms_pkg::PE_PLO] = core_i.pipe[0];
				next_pads.e_oe[bms_pkg::PE_PHI]  = 1'b1;
				next_pads.e_oe[bms_pkg::PE_PLO]  = 1'b1;
			end
		end
		// Single chip skips the block above, so those enables do nothing
		if (!e_clock_disable) begin
			next_pads.e_out[bms_pkg::PE_E_CLOCK_OUT] = e_clock_out_val;
			next_pads.e_oe[bms_pkg::PE_E_CLOCK_OUT]  = 1'b1;
		end
		// Pull-ups on every Port E pin not driven by us
		next_pads.e_pull = ~next_pads.e_oe;
		next_pads.e_pull[bms_pkg::PE_NONMASKABLE_INT_IN] = 1'b1;
		next_pads.e_pull[bms_pkg::PE_IRQ]  = 1'b1;
	end

	// Registered pads; everything floats while reset is held
	// Registering costs one cycle of latency but keeps the pads free
	// of glitches from the combinational mux
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pads_o <= '0;
		end else if (init) begin
			// Mode not yet latched; keep straps undriven one more cycle
			pads_o <= '0;
		end else begin
			pads_o <= next_pads;
		end
	end

endmodule // bms_mode_pins

// *** dv/bms_mode_pins_asserts.sv ***
`timescale 1ns/10ps
module bms_mode_pins_asserts (
	input wire logic                   ref_clk_i,
	input wire logic                   reset_n_i,
	input wire logic                   hreadyout_o,
	input wire logic                   hresp_o,
	input wire bms_pkg::bms_core_bus_t core_i,
	input wire bms_pkg::bms_gpio_t     gpio_i,
	input wire logic                   bdm_activate_i,
	input wire logic                   bdm_active_o,
	input wire logic [2:0]             mode_o,
	input wire logic                   mode_select_hi_i,
	input wire logic [7:0]             port_e_i,
	input wire bms_pkg::bms_pads_t     pads_o
);
	// One clock domain, so one default clock and disable
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Pad mux is live only after the init edge has passed
	sequence s_run;
		reset_n_i [*3];
	endsequence
	property p_bus_ok;
		hreadyout_o && !hresp_o;
	endproperty
	property p_rel_quiet;
		$rose(reset_n_i) |-> pads_o == '0;
	endproperty
	property p_cap;
		// Straps reach the mode three edges after they were sampled
		$rose(reset_n_i) |=> mode_o == {$past(mode_select_hi_i, 3),
			$past(port_e_i[6], 3), $past(port_e_i[5], 3)};
	endproperty
	property p_bdm;
		$rose(reset_n_i) && !bdm_activate_i |=>
			bdm_active_o == (mode_o == bms_pkg::MODE_SSC);
	endproperty
	property p_irq_in;
		s_run |-> pads_o.e_oe[1:0] == 2'h0 && pads_o.e_pull[1:0] == 2'h3
			&& pads_o.ab_pull == 8'h00;
	endproperty
	// Single chip: no bus, port direction comes from the port registers
	property p_single;
		s_run ##0 mode_o[1:0] == 2'h0 |=>
			pads_o.a_oe == $past(gpio_i.a_dir)
			&& pads_o.e_oe[6:5] == $past(gpio_i.e_dir[6:5])
			&& pads_o.e_oe[2] == $past(gpio_i.e_dir[2]);
	endproperty
	property p_narrow_lstr;
		s_run ##0 mode_o == bms_pkg::MODE_NNR |=>
			pads_o.e_oe[3] == $past(gpio_i.e_dir[3]);
	endproperty
	property p_wide_addr;
		s_run ##0 mode_o == bms_pkg::MODE_NWD && core_i.addr_phase |=>
			pads_o.a_oe == 8'hff
			&& {pads_o.a_out, pads_o.b_out} == $past(core_i.addr);
	endproperty
	property p_narrow_data;
		s_run ##0 mode_o == bms_pkg::MODE_NNR && !core_i.addr_phase
			&& !core_i.rw |=> pads_o.a_out == $past(core_i.wdata[7:0])
			&& pads_o.b_out == $past(core_i.addr[7:0]);
	endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("bus not ready or not okay");
	a_rel_quiet: assert property (p_rel_quiet)
		else $error("pads driven during reset");
	a_cap: assert property (p_cap)
		else $error("mode bits differ from straps");
	a_bdm: assert property (p_bdm)
		else $error("debug state wrong after reset");
	a_irq_in: assert property (p_irq_in)
		else $error("interrupt pins or port pulls wrong");
	a_single: assert property (p_single)
		else $error("single chip pin took a bus function");
	a_narrow_lstr: assert property (p_narrow_lstr)
		else $error("narrow strobe pin left general use");
	a_wide_addr: assert property (p_wide_addr)
		else $error("wide address phase wrong");
	a_narrow_data: assert property (p_narrow_data)
		else $error("narrow data phase wrong");
	c_rel: cover property ($rose(reset_n_i));
	c_wide: cover property (s_run ##0 mode_o == bms_pkg::MODE_NWD
		&& core_i.addr_phase);
	c_narrow: cover property (s_run ##0 mode_o == bms_pkg::MODE_NNR);
endmodule // bms_mode_pins_asserts

bind bms_mode_pins bms_mode_pins_asserts bms_mode_pins_asserts_inst (
	.ref_clk_i, .reset_n_i, .hreadyout_o, .hresp_o, .core_i, .gpio_i,
	.bdm_activate_i, .bdm_active_o, .mode_o, .mode_select_hi_i,
	.port_e_i, .pads_o
);

// *** dv/bms_ext_bus.sv ***
`timescale 1ns/10ps
module bms_ext_bus (
	input  wire logic               ref_clk_i,
	input  wire logic               reset_n_i,
	input  wire logic [2:0]         strap_i,
	input  wire bms_pkg::bms_pads_t pads_i,
	output logic                    mode_select_hi_o,
	output logic [7:0]              port_a_o,
	output logic [7:0]              port_b_o,
	output logic [7:0]              port_e_o
);
	logic [7:0] last_a; // Last resolved levels, for floating lines
	logic [7:0] last_b;
	logic [7:0] last_e;
	// A floating line without pull shows the inverse of its last level,
	// so a stale value never passes for a driven one
	function automatic logic [7:0] lvl(input logic [7:0] o, oe, pu, l);
		return (oe & o) | (~oe & pu) | (~oe & ~pu & ~l);
	endfunction
	assign mode_select_hi_o = strap_i[2];
	assign port_a_o = lvl(pads_i.a_out, pads_i.a_oe, pads_i.ab_pull, last_a);
	assign port_b_o = lvl(pads_i.b_out, pads_i.b_oe, pads_i.ab_pull, last_b);
	// Straps sit on the shared E lines while reset leaves them undriven
	always_comb begin
		port_e_o = lvl(pads_i.e_out, pads_i.e_oe, pads_i.e_pull, last_e);
		if (!reset_n_i) begin
			port_e_o[6:5] = strap_i[1:0];
		end
	end
	// Remember levels; reset gives them a known start
	always_ff @(posedge ref_clk_i) begin
		last_a <= reset_n_i ? port_a_o : 8'h00;
		last_b <= reset_n_i ? port_b_o : 8'h00;
		last_e <= reset_n_i ? port_e_o : 8'h00;
	end
endmodule // bms_ext_bus

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
	logic                   ref_clk_i;
	logic                   reset_n_i;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hready;
	bms_pkg::bms_core_bus_t core;   // Core cycle pattern; tests toggle addr_phase and internal
	bms_pkg::bms_gpio_t     gpio;   // Port registers, all inputs
	bms_pkg::bms_pads_t     pads;
	logic [2:0]             strap;  // Mode straps for next reset
	logic [2:0]             mode;
	logic                   mode_hi;
	logic [7:0]             pa;
	logic [7:0]             pb;
	logic [7:0]             pe;
	logic [31:0]            rd;     // Last read data
	logic [23:0]            pin_in; // Synchronised pad levels
	logic                   bdm_go; // Debug activation pulse
	logic                   bdm_stop; // Debug release pulse
	int                     failures;
	int                     checked;

	bms_mode_pins bms_mode_pins_inst (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
		.core_i(core), .gpio_i(gpio), .bdm_activate_i(bdm_go),
		.bdm_release_i(bdm_stop), .bdm_active_o(), .mode_o(mode),
		.mode_select_hi_i(mode_hi), .port_a_i(pa), .port_b_i(pb),
		.port_e_i(pe), .pads_o(pads), .pin_in_o(pin_in)
	);
	bms_ext_bus bms_ext_bus_inst (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .strap_i(strap),
		.pads_i(pads), .mode_select_hi_o(mode_hi), .port_a_o(pa),
		.port_b_o(pb), .port_e_o(pe)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic summarize;
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One AHB-Lite single transfer; waits on hready in both phases
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge ref_clk_i);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge ref_clk_i);
		while (hready !== 1'b1) @(posedge ref_clk_i);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge ref_clk_i);
		while (hready !== 1'b1) @(posedge ref_clk_i);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	// Four reset cycles; straps held well past the synchronisers
	task automatic boot(input logic [2:0] m);
		@(posedge ref_clk_i);
		strap     <= m;
		reset_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
	endtask
	// Pads lag the registers by one cycle
	task automatic settle;
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic t_straps;
		logic [2:0] m;
		logic [5:0] st;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			st = {~m[2], m inside {3'h2, 3'h3, 3'h7},
				m inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7}, 2'h0, m == 3'h0};
			if (m != bms_pkg::MODE_PER) begin
				boot(m);
				chk(32'(mode), 32'(m));
				rdc(bms_pkg::STAT_OFS, 32'(st));
				rdc(bms_pkg::EBI_OFS, 32'(m[2]));
				rdc(bms_pkg::PORT_E_ASSIGN_REG_OFS, (m == 3'h4) ? 32'h10 : 32'h0);
			end
		end
	endtask
	task automatic t_single;
		boot(bms_pkg::MODE_NSC);
		wr(bms_pkg::PORT_E_ASSIGN_REG_OFS, 8'h2c);
		settle;
		chk(32'(pads.e_oe & 8'h7c), 32'h10);
		rdc(bms_pkg::PORT_E_ASSIGN_REG_OFS, 32'h2c);
		wr(bms_pkg::MODE_OFS, 8'h88);
		wr(bms_pkg::MODE_OFS, 8'he0);
		rdc(bms_pkg::MODE_OFS, 32'h88);
		rdc(bms_pkg::STAT_OFS, 32'h02);
		boot(bms_pkg::MODE_NSC);
		wr(bms_pkg::MODE_OFS, 8'ha8);
		rdc(bms_pkg::MODE_OFS, 32'ha8);
		// Narrow now, visibility set: internal cycles must stay hidden
		wr(bms_pkg::PORT_E_ASSIGN_REG_OFS, 8'h00);
		core.internal <= 1'b1;
		settle;
		chk(32'(pads.e_out[4]), 32'h0);
		@(posedge ref_clk_i);
		core.internal <= 1'b0;
	endtask
	task automatic t_narrow;
		boot(bms_pkg::MODE_NNR);
		@(posedge ref_clk_i);
		bdm_go <= 1'b1;
		@(posedge ref_clk_i);
		bdm_go <= 1'b0;
		rdc(bms_pkg::STAT_OFS, 32'h09);
		bdm_stop <= 1'b1;
		@(posedge ref_clk_i);
		bdm_stop <= 1'b0;
		rdc(bms_pkg::STAT_OFS, 32'h08);
		wr(bms_pkg::PORT_E_ASSIGN_REG_OFS, 8'h2c);
		wr(bms_pkg::PORT_E_ASSIGN_REG_OFS, 8'h00);
		rdc(bms_pkg::PORT_E_ASSIGN_REG_OFS, 32'h2c);
		settle;
		chk(32'(pads.e_oe & 8'h6c), 32'h64);
		chk(32'({pads.e_out[6:5], pads.e_out[2]}), 32'h4);
		@(posedge ref_clk_i);
		core.internal <= 1'b1;
		wr(bms_pkg::MODE_OFS, 8'ha8);
		rdc(bms_pkg::MODE_OFS, 32'ha0);
		settle;
		chk(32'(pads.e_out[4]), 32'h0);
		@(posedge ref_clk_i);
		core.internal <= 1'b0;
	endtask
	task automatic t_wide;
		boot(bms_pkg::MODE_NWD);
		settle;
		chk(32'(pads.e_oe & 8'h7c), 32'h10);
		wr(bms_pkg::PORT_E_ASSIGN_REG_OFS, 8'h08);
		core.addr_phase <= 1'b1;
		settle;
		chk(32'(pads.e_oe & 8'h7c), 32'h18);
		chk(32'({pads.a_out, pads.b_out}), 32'h1234);
		settle;
		chk(32'(pin_in[23:8]), 32'h1234);
		@(posedge ref_clk_i);
		core.addr_phase <= 1'b0;
	endtask
	task automatic t_special;
		boot(bms_pkg::MODE_SSC);
		wr(bms_pkg::MODE_OFS, 8'h68);
		wr(bms_pkg::MODE_OFS, 8'h20);
		rdc(bms_pkg::MODE_OFS, 32'h20);
		wr(8'h10, 8'hff);
		rdc(8'h10, 32'h0);
	endtask

	// Main sequence; core pattern: rw 0, strobe 0, pipe 10, clocks 1
	initial begin
		reset_n_i = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		strap = 3'h4;
		core = {16'h1234, 16'habcd, 8'h2c};
		gpio = '0;
		bdm_go = 1'b0;
		bdm_stop = 1'b0;
		failures = 0;
		checked = 0;
		t_straps;
		t_single;
		t_narrow;
		t_wide;
		t_special;
		summarize;
	end
	// Watchdog: the whole run needs well under 4000 cycles
	initial begin
		#100000;
		failures++;
		summarize;
	end
endmodule // tb
